/* File: hdl/dcf_defs.vh */
// Constants shared by the dual clock FIFO with mailboxes.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH

// ****************************************************************
// Storage geometry
// ****************************************************************
`define DCF_DW          36
`define DCF_AW          6
`define DCF_PW          7
`define DCF_DEPTH       7'h40
`define DCF_LANES       4
`define DCF_LANE_W      9

// ****************************************************************
// Preset offsets chosen by the offset select pins at reset release
// ****************************************************************
`define DCF_OFFSET_0    7'h10
`define DCF_OFFSET_1    7'h0c
`define DCF_OFFSET_2    7'h08
`define DCF_OFFSET_3    7'h04

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define DCF_RA_W        5
`define DCF_REG_CTRL    5'h00
`define DCF_REG_STATE   5'h04
`define DCF_REG_STATUS  5'h08
`define DCF_REG_ENABLE  5'h0c
`define DCF_REG_CLEAR   5'h10

// Control register fields.
`define DCF_CTRL_GEN_A  0
`define DCF_CTRL_GEN_B  1
`define DCF_CTRL_ODD    2
`define DCF_CTRL_W      3
`define DCF_CTRL_RST    3'h0

// State register field positions.
`define DCF_ST_CNT_A    0
`define DCF_ST_CNT_B    8
`define DCF_ST_OFS      16

// Event bits of status, enable and clear registers.
`define DCF_EV_W        6
`define DCF_EV_PAR_A    0
`define DCF_EV_PAR_B    1
`define DCF_EV_MAIL_AB  2
`define DCF_EV_MAIL_BA  3
`define DCF_EV_WR_FULL  4
`define DCF_EV_RD_EMPTY 5
`define DCF_EV_RST      6'h00

// Pin bundle layout after synchronisation.
`define DCF_PIN_W       41
`define DCF_PIN_CLK     40
`define DCF_PIN_SEL_N   39
`define DCF_PIN_GATE    38
`define DCF_PIN_WRITE   37
`define DCF_PIN_MAIL    36

`endif

/* File: hdl/dcf_sync2.v */
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes the destination logic reads only the second stage.
`timescale 1ns/100ps

module dcf_sync2 #(
    parameter W = 1
) (
    input  wire         ref_clk_in,  // System clock
    input  wire         sys_rst_in,  // Synchronous reset, active high
    input  wire [W-1:0] async_in,    // Levels from outside the domain
    output reg  [W-1:0] sync_out     // Second stage
);

    reg [W-1:0] stage1;

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            stage1   <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // dcf_sync2

/* File: hdl/dcf_parity.v */
// Per-lane parity check and generation for one 36-bit word.
// Assumes four 9-bit lanes, the parity bit at the top of each lane.
`timescale 1ns/100ps
`include "dcf_defs.vh"

module dcf_parity (
    input  wire [`DCF_DW-1:0]    data_in,  // Word to check or regenerate
    input  wire                  odd_in,   // High selects odd parity
    output wire [`DCF_DW-1:0]    gen_out,  // Word with fresh parity bits
    output wire                  err_out   // High when any lane mismatches
);

    wire [`DCF_LANES-1:0] lane_err;

    genvar g;
    generate
        for (g = 0; g < `DCF_LANES; g = g + 1) begin : lane
            wire p;
            assign p = (^data_in[g*`DCF_LANE_W +: `DCF_LANE_W-1]) ^ odd_in;
            assign gen_out[g*`DCF_LANE_W +: `DCF_LANE_W-1] =
                data_in[g*`DCF_LANE_W +: `DCF_LANE_W-1];
            assign gen_out[g*`DCF_LANE_W+`DCF_LANE_W-1] = p;
            assign lane_err[g] = p ^ data_in[g*`DCF_LANE_W+`DCF_LANE_W-1];
        end
    endgenerate

    assign err_out = |lane_err;

endmodule // dcf_parity

/* File: hdl/dcf_fifo.v */
// Dual port FIFO of 64 words by 36 bits with a mailbox each way.
// Assumes both port clocks are slow pin levels well below ref_clk_in,
// sampled here and turned into one-cycle edge pulses.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`include "dcf_defs.vh"

module dcf_fifo (
    input  wire                 ref_clk_in,              // 125 MHz clock
    input  wire                 sys_rst_in,              // Sync reset
    input  wire                 port_a_clock_in,         // Port A clock pin
    input  wire                 port_a_select_n_in,      // Port A select
    input  wire                 port_a_transfer_gate_in, // Port A gate
    input  wire                 port_a_write_in,         // A: high writes
    input  wire                 port_a_mail_pick_in,     // A: mailbox
    input  wire [`DCF_DW-1:0]   port_a_bus_in,           // A bus level
    output reg  [`DCF_DW-1:0]   port_a_bus_out,          // A bus drive
    output reg                  port_a_bus_oe_n_out,     // A drive, low
    input  wire                 port_b_clock_in,         // Port B clock pin
    input  wire                 port_b_select_n_in,      // Port B select
    input  wire                 port_b_transfer_gate_in, // Port B gate
    input  wire                 port_b_write_in,         // B: high writes
    input  wire                 port_b_mail_pick_in,     // B: mailbox
    input  wire [`DCF_DW-1:0]   port_b_bus_in,           // B bus level
    output reg  [`DCF_DW-1:0]   port_b_bus_out,          // B bus drive
    output reg                  port_b_bus_oe_n_out,     // B drive, low
    input  wire [1:0]           offset_select_in,        // Offset pins
    output reg                  full_flag_n_out,         // Full, low
    output reg                  near_full_flag_n_out,    // Near full, low
    output reg                  empty_indicator_n_out,   // Empty, low
    output reg                  near_empty_flag_n_out,   // Near empty, low
    output reg                  mail_ab_flag_n_out,      // A to B mail
    output reg                  mail_ba_flag_n_out,      // B to A mail
    input  wire [`DCF_RA_W-1:0] reg_addr_in,             // Register addr
    input  wire [31:0]          reg_wdata_in,            // Write data
    input  wire                 reg_wr_in,               // Write strobe
    input  wire                 reg_rd_in,               // Read strobe
    output reg  [31:0]          reg_rdata_out,           // Read data
    output reg                  irq_out                  // Interrupt level
);

    // ****************************************************************
    // Pin synchronisation and port clock edges
    // ****************************************************************
    wire [`DCF_PIN_W-1:0] pa;
    wire [`DCF_PIN_W-1:0] pb;
    wire [1:0]            ofs_sel;

    // Synchronisers run through reset, so pins read true at release.
    dcf_sync2 #(.W(`DCF_PIN_W)) u_sync_a (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (1'b0),
        .async_in   ({port_a_clock_in, port_a_select_n_in,
                      port_a_transfer_gate_in, port_a_write_in,
                      port_a_mail_pick_in, port_a_bus_in}),
        .sync_out   (pa)
    );

    dcf_sync2 #(.W(`DCF_PIN_W)) u_sync_b (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (1'b0),
        .async_in   ({port_b_clock_in, port_b_select_n_in,
                      port_b_transfer_gate_in, port_b_write_in,
                      port_b_mail_pick_in, port_b_bus_in}),
        .sync_out   (pb)
    );

    dcf_sync2 #(.W(2)) u_sync_ofs (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (1'b0),
        .async_in   (offset_select_in),
        .sync_out   (ofs_sel)
    );

    reg  a_clk_q;
    reg  b_clk_q;
    wire a_edge = pa[`DCF_PIN_CLK] & ~a_clk_q;
    wire b_edge = pb[`DCF_PIN_CLK] & ~b_clk_q;
    wire a_act  = a_edge & ~pa[`DCF_PIN_SEL_N] & pa[`DCF_PIN_GATE];
    wire b_act  = b_edge & ~pb[`DCF_PIN_SEL_N] & pb[`DCF_PIN_GATE];
    wire a_wr   = a_act & pa[`DCF_PIN_WRITE];
    wire a_rd   = a_act & ~pa[`DCF_PIN_WRITE];
    wire b_wr   = b_act & pb[`DCF_PIN_WRITE];
    wire b_rd   = b_act & ~pb[`DCF_PIN_WRITE];
    wire a_mail = pa[`DCF_PIN_MAIL];
    wire b_mail = pb[`DCF_PIN_MAIL];

    // ****************************************************************
    // Control registers and parity
    // ****************************************************************
    reg  [`DCF_CTRL_W-1:0] ctrl;
    reg  [`DCF_PW-1:0]     offset;
    reg                    rst_q;
    wire                   odd = ctrl[`DCF_CTRL_ODD];
    wire [`DCF_DW-1:0]     a_gen;
    wire [`DCF_DW-1:0]     b_gen;
    wire                   a_perr;
    wire                   b_perr;
    wire [`DCF_DW-1:0]     a_src;
    wire [`DCF_DW-1:0]     b_src;
    wire [`DCF_DW-1:0]     a_src_gen;
    wire [`DCF_DW-1:0]     b_src_gen;
    wire                   unused_a;
    wire                   unused_b;

    // Checkers look at incoming words only; data is stored unchanged.
    dcf_parity u_chk_a (
        .data_in (pa[`DCF_DW-1:0]),
        .odd_in  (odd),
        .gen_out (a_gen),
        .err_out (a_perr)
    );

    dcf_parity u_chk_b (
        .data_in (pb[`DCF_DW-1:0]),
        .odd_in  (odd),
        .gen_out (b_gen),
        .err_out (b_perr)
    );

    dcf_parity u_gen_a (
        .data_in (a_src),
        .odd_in  (odd),
        .gen_out (a_src_gen),
        .err_out (unused_a)
    );

    dcf_parity u_gen_b (
        .data_in (b_src),
        .odd_in  (odd),
        .gen_out (b_src_gen),
        .err_out (unused_b)
    );

    // ****************************************************************
    // Storage, pointers and Gray code crossing
    // ****************************************************************
    reg [`DCF_DW-1:0] mem [0:`DCF_DEPTH-1];
    reg [`DCF_DW-1:0] mail_ab;
    reg [`DCF_DW-1:0] mail_ba;
    reg [`DCF_PW-1:0] wptr;
    reg [`DCF_PW-1:0] rptr;
    reg [`DCF_PW-1:0] wgray;
    reg [`DCF_PW-1:0] rgray;
    reg [`DCF_PW-1:0] wg_s1;
    reg [`DCF_PW-1:0] wg_s2;
    reg [`DCF_PW-1:0] rg_s1;
    reg [`DCF_PW-1:0] rg_s2;
    reg [1:0]         a_ready;

    function [`DCF_PW-1:0] g2b;
        input [`DCF_PW-1:0] g;
        integer i;
        begin
            g2b[`DCF_PW-1] = g[`DCF_PW-1];
            for (i = `DCF_PW-2; i >= 0; i = i - 1) begin
                g2b[i] = g2b[i+1] ^ g[i];
            end
        end
    endfunction

    wire [`DCF_PW-1:0] next_wptr = wptr + 7'h01;
    wire [`DCF_PW-1:0] next_rptr = rptr + 7'h01;
    wire [`DCF_PW-1:0] cnt_a     = wptr - g2b(rg_s2);
    wire [`DCF_PW-1:0] free_a    = `DCF_DEPTH - cnt_a;
    wire [`DCF_PW-1:0] cnt_b     = g2b(wg_s2) - rptr;
    wire               fifo_wr   = a_wr & ~a_mail & full_flag_n_out;
    wire               fifo_rd   = b_rd & ~b_mail & empty_indicator_n_out;
    wire               ab_wr     = a_wr & a_mail & mail_ab_flag_n_out;
    wire               ba_wr     = b_wr & b_mail & mail_ba_flag_n_out;
    wire               ab_rd     = b_rd & b_mail;
    wire               ba_rd     = a_rd & a_mail;

    assign b_src = b_mail ? mail_ab : mem[rptr[`DCF_AW-1:0]];
    assign a_src = mail_ba;

    always @(posedge ref_clk_in) begin
        if (fifo_wr) begin
            mem[wptr[`DCF_AW-1:0]] <= pa[`DCF_DW-1:0];
        end
    end

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            a_clk_q <= 1'b0;
            b_clk_q <= 1'b0;
            wptr    <= 7'h00;
            rptr    <= 7'h00;
            wgray   <= 7'h00;
            rgray   <= 7'h00;
            wg_s1   <= 7'h00;
            wg_s2   <= 7'h00;
            rg_s1   <= 7'h00;
            rg_s2   <= 7'h00;
            a_ready <= 2'h0;
        end else begin
            a_clk_q <= pa[`DCF_PIN_CLK];
            b_clk_q <= pb[`DCF_PIN_CLK];
            if (a_edge) begin
                a_ready <= {a_ready[0], 1'b1};
                rg_s1   <= rgray;
                rg_s2   <= rg_s1;
            end
            if (b_edge) begin
                wg_s1 <= wgray;
                wg_s2 <= wg_s1;
            end
            // The two sides never share a register, so one cycle may
            // carry both an A write and a B read.
            if (fifo_wr) begin
                wptr  <= next_wptr;
                wgray <= next_wptr ^ (next_wptr >> 1);
            end
            if (fifo_rd) begin
                rptr  <= next_rptr;
                rgray <= next_rptr ^ (next_rptr >> 1);
            end
        end
    end

    // ****************************************************************
    // Flags, mailboxes and port buses
    // ****************************************************************
    // Flags follow the second sync stage within one cycle, long before
    // the next slow port edge, so they appear as changed by that edge.
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            full_flag_n_out       <= 1'b0;
            near_full_flag_n_out  <= 1'b0;
            empty_indicator_n_out <= 1'b0;
            near_empty_flag_n_out <= 1'b0;
            mail_ab_flag_n_out    <= 1'b1;
            mail_ba_flag_n_out    <= 1'b1;
            mail_ab               <= {`DCF_DW{1'b0}};
            mail_ba               <= {`DCF_DW{1'b0}};
            port_a_bus_out        <= {`DCF_DW{1'b0}};
            port_b_bus_out        <= {`DCF_DW{1'b0}};
            port_a_bus_oe_n_out   <= 1'b1;
            port_b_bus_oe_n_out   <= 1'b1;
        end else begin
            full_flag_n_out       <= a_ready[1] &
                                     (cnt_a != `DCF_DEPTH);
            near_full_flag_n_out  <= a_ready[1] &
                                     (free_a > offset);
            empty_indicator_n_out <= (cnt_b != 7'h00);
            near_empty_flag_n_out <= (cnt_b > offset);
            if (ab_wr) begin
                mail_ab            <= pa[`DCF_DW-1:0];
                mail_ab_flag_n_out <= 1'b0;
            end else if (ab_rd) begin
                mail_ab_flag_n_out <= 1'b1;
            end
            if (ba_wr) begin
                mail_ba            <= pb[`DCF_DW-1:0];
                mail_ba_flag_n_out <= 1'b0;
            end else if (ba_rd) begin
                mail_ba_flag_n_out <= 1'b1;
            end
            // Bus drive follows select and direction; data changes only
            // on a qualified read edge.
            port_a_bus_oe_n_out <= pa[`DCF_PIN_SEL_N] |
                                   pa[`DCF_PIN_WRITE];
            port_b_bus_oe_n_out <= pb[`DCF_PIN_SEL_N] |
                                   pb[`DCF_PIN_WRITE];
            if (ba_rd) begin
                port_a_bus_out <= ctrl[`DCF_CTRL_GEN_A] ?
                                  a_src_gen : a_src;
            end
            if (ab_rd | fifo_rd) begin
                port_b_bus_out <= ctrl[`DCF_CTRL_GEN_B] ?
                                  b_src_gen : b_src;
            end
        end
    end

    // ****************************************************************
    // Offset load at reset release
    // ****************************************************************
    always @(posedge ref_clk_in) begin
        rst_q <= sys_rst_in;
        if (rst_q & ~sys_rst_in) begin
            case (ofs_sel)
                2'h0: offset <= `DCF_OFFSET_0;
                2'h1: offset <= `DCF_OFFSET_1;
                2'h2: offset <= `DCF_OFFSET_2;
                2'h3: offset <= `DCF_OFFSET_3;
                default: offset <= `DCF_OFFSET_0;
            endcase
        end else if (sys_rst_in) begin
            offset <= `DCF_OFFSET_0;
        end
    end

    // ****************************************************************
    // Register port and interrupt
    // ****************************************************************
    reg  [`DCF_EV_W-1:0] status;
    reg  [`DCF_EV_W-1:0] irq_en;
    wire [`DCF_EV_W-1:0] events;
    wire [`DCF_EV_W-1:0] clr;

    assign events[`DCF_EV_PAR_A]    = a_wr & a_perr;
    assign events[`DCF_EV_PAR_B]    = b_wr & b_perr;
    assign events[`DCF_EV_MAIL_AB]  = ab_wr;
    assign events[`DCF_EV_MAIL_BA]  = ba_wr;
    assign events[`DCF_EV_WR_FULL]  = a_wr & ~a_mail & ~full_flag_n_out;
    assign events[`DCF_EV_RD_EMPTY] = b_rd & ~b_mail &
                                      ~empty_indicator_n_out;
    assign clr = (reg_wr_in && reg_addr_in == `DCF_REG_CLEAR) ?
                 reg_wdata_in[`DCF_EV_W-1:0] : `DCF_EV_RST;

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl          <= `DCF_CTRL_RST;
            irq_en        <= `DCF_EV_RST;
            status        <= `DCF_EV_RST;
            reg_rdata_out <= 32'h0000_0000;
            irq_out       <= 1'b0;
        end else begin
            // A new event wins over a clear in the same cycle.
            status  <= (status & ~clr) | events;
            irq_out <= |(status & irq_en);
            if (reg_wr_in && reg_addr_in == `DCF_REG_CTRL) begin
                ctrl <= reg_wdata_in[`DCF_CTRL_W-1:0];
            end
            if (reg_wr_in && reg_addr_in == `DCF_REG_ENABLE) begin
                irq_en <= reg_wdata_in[`DCF_EV_W-1:0];
            end
            reg_rdata_out <= 32'h0000_0000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `DCF_REG_CTRL:
                        reg_rdata_out[`DCF_CTRL_W-1:0] <= ctrl;
                    `DCF_REG_STATE: begin
                        reg_rdata_out[`DCF_ST_CNT_A +: `DCF_PW] <= cnt_a;
                        reg_rdata_out[`DCF_ST_CNT_B +: `DCF_PW] <= cnt_b;
                        reg_rdata_out[`DCF_ST_OFS +: `DCF_PW]   <= offset;
                    end
                    `DCF_REG_STATUS:
                        reg_rdata_out[`DCF_EV_W-1:0] <= status;
                    `DCF_REG_ENABLE:
                        reg_rdata_out[`DCF_EV_W-1:0] <= irq_en;
                    default:
                        reg_rdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // dcf_fifo

/* File: hdl/dcf_fifo_unused_placeholder_removed.v */
// Intentionally empty: no module in this file.

/* File: tb/dcf_fifo_asserts.sv */
// Checker on the pins of the dual clock FIFO.
// Assumes port clock pins rest low between the transfers of the masters.
`timescale 1ns/100ps
module dcf_fifo_asserts (
    input wire ref_clk_in,            // System clock
    input wire sys_rst_in,            // Sync reset
    input wire port_a_clock_in,       // Port A clock pin
    input wire port_b_clock_in,       // Port B clock pin
    input wire port_a_select_n_in,    // Port A select
    input wire port_b_select_n_in,    // Port B select
    input wire port_a_bus_oe_n_out,   // A drive, low
    input wire port_b_bus_oe_n_out,   // B drive, low
    input wire full_flag_n_out,       // Full
    input wire empty_indicator_n_out, // Empty
    input wire mail_ab_flag_n_out,    // A to B mail
    input wire mail_ba_flag_n_out     // B to A mail
);
    // Cycles since a port clock pin was high; a flag owned by one port may
    // move only shortly after that port's edge, never on the other's.
    reg [3:0] a_idle;
    reg [3:0] b_idle;
    always @(posedge ref_clk_in) begin
        a_idle <= (port_a_clock_in | sys_rst_in) ? 4'h0 :
                  a_idle + {3'h0, a_idle != 4'hf};
        b_idle <= (port_b_clock_in | sys_rst_in) ? 4'h0 :
                  b_idle + {3'h0, b_idle != 4'hf};
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    AST_EMPTY_RST: assert property (
        $past(sys_rst_in) |-> !empty_indicator_n_out) else $error("empty");
    AST_FULL_RST: assert property (
        $past(sys_rst_in) |-> !full_flag_n_out) else $error("full");
    AST_MAIL_RST: assert property (
        $past(sys_rst_in) |-> mail_ab_flag_n_out && mail_ba_flag_n_out)
        else $error("mail flags after reset");
    AST_A_DRIVE: assert property (
        !port_a_bus_oe_n_out |-> !$past(port_a_select_n_in, 3))
        else $error("A bus driven while unselected");
    AST_B_DRIVE: assert property (
        !port_b_bus_oe_n_out |-> !$past(port_b_select_n_in, 3))
        else $error("B bus driven while unselected");
    AST_EMPTY_B: assert property (
        $changed(empty_indicator_n_out) |-> b_idle < 4'h6)
        else $error("empty moved away from a B edge");
    AST_FULL_A: assert property (
        $changed(full_flag_n_out) |-> a_idle < 4'h6)
        else $error("full moved away from an A edge");
    AST_MAB_SET: assert property (
        $fell(mail_ab_flag_n_out) |-> a_idle < 4'h6) else $error("mab set");
    AST_MAB_READ: assert property (
        $rose(mail_ab_flag_n_out) |-> b_idle < 4'h6) else $error("mab read");
    AST_MBA_SET: assert property (
        $fell(mail_ba_flag_n_out) |-> b_idle < 4'h6) else $error("mba set");
endmodule // dcf_fifo_asserts
bind dcf_fifo dcf_fifo_asserts dcf_fifo_asserts_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .port_a_clock_in(port_a_clock_in), .port_b_clock_in(port_b_clock_in),
    .port_a_select_n_in(port_a_select_n_in),
    .port_b_select_n_in(port_b_select_n_in),
    .port_a_bus_oe_n_out(port_a_bus_oe_n_out),
    .port_b_bus_oe_n_out(port_b_bus_oe_n_out),
    .full_flag_n_out(full_flag_n_out),
    .empty_indicator_n_out(empty_indicator_n_out),
    .mail_ab_flag_n_out(mail_ab_flag_n_out),
    .mail_ba_flag_n_out(mail_ba_flag_n_out));

/* File: tb/dcf_master.sv */
// Bus master model for one port of the FIFO.
// Assumes the device samples these pins through a two-flop synchroniser.
`timescale 1ns/100ps
module dcf_master (
    input  wire        ref_clk_in, // System clock
    input  wire        oe_n_in,    // Device drive, low
    input  wire [35:0] dev_in,     // Device drive data
    output reg         clk_out,    // Port clock pin
    output reg         sel_n_out,  // Port select, low
    output reg         gate_out,   // Transfer gate
    output reg         write_out,  // High writes
    output reg         mail_out,   // High picks mailbox
    output wire [35:0] bus_out     // Resolved bus level
);
    reg [35:0] drv;
    assign bus_out = oe_n_in ? drv : dev_in;
    initial begin
        {clk_out, gate_out, write_out, mail_out} = 4'h0;
        sel_n_out = 1'b1;
        drv = 36'h0;
    end
    // Controls settle two cycles before the edge and hold past the sync.
    task xfer(input g, input w, input m, input [35:0] d, output [35:0] q);
            @(posedge ref_clk_in);
            sel_n_out <= ~g;
            gate_out <= g;
            write_out <= w;
            mail_out <= m;
            if (w)
                drv <= d;
            repeat (2) @(posedge ref_clk_in);
            clk_out <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            clk_out <= 1'b0;
            repeat (4) @(posedge ref_clk_in);
            q = bus_out;
            sel_n_out <= 1'b1;
            gate_out <= 1'b0;
            // A released bus shows the inverse, so stale data cannot match.
            drv <= ~bus_out;
    endtask
endmodule // dcf_master

/* File: tb/testbench.sv */
// Self-checking bench for the dual clock FIFO with mailboxes.
// Assumes one master model per port and offset preset 0 at reset.
`timescale 1ns/100ps
`include "dcf_defs.vh"
module testbench;
    reg         ref_clk = 1'b0;
    reg         rst = 1'b1;
    reg  [4:0]  addr = 5'h00;
    reg  [31:0] wdata = 32'h0;
    reg         wr = 1'b0, rd = 1'b0;
    reg  [1:0]  ofs = 2'h0;
    reg  [35:0] q, p;
    integer     k;
    integer     failures = 0;
    integer     num_checks = 0;
    wire [35:0] a_out, b_out, a_bus, b_bus;
    wire [31:0] rdata;
    wire        a_oe_n, b_oe_n, a_clk, b_clk, a_sel_n, b_sel_n, a_gt, b_gt;
    wire        a_wr, b_wr, a_mb, b_mb, ff_n, nf_n, ef_n, ne_n, mab_n, mba_n;
    wire        irq;
    always #4 ref_clk = ~ref_clk;
    dcf_master port_a_master (.ref_clk_in(ref_clk), .oe_n_in(a_oe_n),
        .dev_in(a_out), .clk_out(a_clk), .sel_n_out(a_sel_n),
        .gate_out(a_gt), .write_out(a_wr), .mail_out(a_mb), .bus_out(a_bus));
    dcf_master port_b_master (.ref_clk_in(ref_clk), .oe_n_in(b_oe_n),
        .dev_in(b_out), .clk_out(b_clk), .sel_n_out(b_sel_n),
        .gate_out(b_gt), .write_out(b_wr), .mail_out(b_mb), .bus_out(b_bus));
    dcf_fifo dcf_fifo_inst (.ref_clk_in(ref_clk), .sys_rst_in(rst),
        .port_a_clock_in(a_clk), .port_a_select_n_in(a_sel_n),
        .port_a_transfer_gate_in(a_gt), .port_a_write_in(a_wr),
        .port_a_mail_pick_in(a_mb), .port_a_bus_in(a_bus),
        .port_a_bus_out(a_out), .port_a_bus_oe_n_out(a_oe_n),
        .port_b_clock_in(b_clk), .port_b_select_n_in(b_sel_n),
        .port_b_transfer_gate_in(b_gt), .port_b_write_in(b_wr),
        .port_b_mail_pick_in(b_mb), .port_b_bus_in(b_bus),
        .port_b_bus_out(b_out), .port_b_bus_oe_n_out(b_oe_n),
        .offset_select_in(ofs), .full_flag_n_out(ff_n),
        .near_full_flag_n_out(nf_n), .empty_indicator_n_out(ef_n),
        .near_empty_flag_n_out(ne_n), .mail_ab_flag_n_out(mab_n),
        .mail_ba_flag_n_out(mba_n), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .irq_out(irq));
    task chk(input [63:0] nm, input [35:0] seen, input [35:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("mismatch %0s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wreg(input [4:0] a, input [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task rreg(input [4:0] a, input [31:0] m, input [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 chk("reg", {4'h0, rdata & m}, {4'h0, e});
    endtask
    task end_sim;
        begin
            $display("checks %0d failures %0d", num_checks, failures);
            if (failures == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        failures = failures + 1;
        end_sim;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        chk("rst", {ff_n, ef_n, mab_n, mba_n}, 4'h3);
        rst <= 1'b0;
        repeat (2) port_a_master.xfer(0, 0, 0, 36'h0, q);
        chk("flags", {ff_n, nf_n, ef_n, ne_n}, 4'hc);
        rreg(5'h14, 32'hffffffff, 32'h0);
        wreg(`DCF_REG_ENABLE, 32'h3f);
        rreg(`DCF_REG_ENABLE, 32'hffffffff, 32'h3f);
        $display("test reset done");
        for (k = 0; k < 65; k = k + 1) begin
            port_a_master.xfer(1, 1, 0, k, q);
            chk("full", {ff_n, nf_n}, {k < 63, k < 47});
            if (k < 2) rreg(`DCF_REG_STATUS, 32'h1, k);
        end
        rreg(`DCF_REG_STATUS, 32'h10, 32'h10);
        repeat (2) port_b_master.xfer(0, 0, 0, 36'h0, q);
        chk("empty", {ef_n, ne_n}, 2'h3);
        for (k = 0; k < 64; k = k + 1) begin
            port_b_master.xfer(1, 0, 0, 36'h0, q);
            chk("data", q, k);
            chk("empty", {ef_n, ne_n}, {k < 63, k < 47});
        end
        port_b_master.xfer(1, 0, 0, 36'h0, q);
        rreg(`DCF_REG_STATUS, 32'h20, 32'h20);
        $display("test fifo done");
        port_a_master.xfer(1, 1, 1, 36'h987654321, q);
        port_a_master.xfer(1, 1, 1, 36'h1, q);
        chk("mab", mab_n, 0);
        port_b_master.xfer(1, 0, 1, 36'h0, q);
        chk("mbox", q, 36'h987654321);
        chk("mab", mab_n, 1);
        port_b_master.xfer(1, 1, 1, 36'h246813579, q);
        chk("mba", mba_n, 0);
        wreg(`DCF_REG_CTRL, 32'h5);
        port_a_master.xfer(1, 0, 1, 36'h0, q);
        chk("mbox", {q[35:1], mba_n}, 36'ha46833479);
        $display("test mail done");
        wreg(`DCF_REG_CTRL, 32'h2);
        port_a_master.xfer(1, 1, 0, 36'h1, q);
        repeat (2) port_b_master.xfer(0, 0, 0, 36'h0, q);
        fork
            port_a_master.xfer(1, 1, 0, 36'h7, p);
            port_b_master.xfer(1, 0, 0, 36'h0, q);
        join
        chk("gen", q, 36'h101);
        repeat (2) port_b_master.xfer(0, 0, 0, 36'h0, q);
        port_b_master.xfer(1, 0, 0, 36'h0, q);
        chk("gen", q, 36'h107);
        rreg(`DCF_REG_STATUS, 32'h3d, 32'h3d);
        chk("irq", irq, 1);
        wreg(`DCF_REG_ENABLE, 32'h0);
        repeat (2) @(posedge ref_clk);
        #1 chk("irq", irq, 0);
        wreg(`DCF_REG_ENABLE, 32'h3f);
        wreg(`DCF_REG_CLEAR, 32'h3f);
        rreg(`DCF_REG_STATUS, 32'h3f, 32'h0);
        chk("irq", irq, 0);
        $display("test parity and irq done");
        @(posedge ref_clk);
        ofs <= 2'h3;
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rreg(`DCF_REG_STATE, 32'h7f7f7f, 32'h40000);
        $display("test offset done");
        end_sim;
    end
endmodule // testbench
